// [inc/modulator_pkg.sv]
// Register map, field positions and reset values of the signal modulator
package modulator_pkg;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [3:0] modulator_control_addr    = 4'h0;
  localparam logic [3:0] modulation_source_addr    = 4'h4;
  localparam logic [3:0] carrier_high_control_addr = 4'h8;
  localparam logic [3:0] carrier_low_control_addr  = 4'hc;

  // ------------------------------------------------------------------
  // Source selection width and count
  // ------------------------------------------------------------------
  localparam int          src_sel_width = 4;
  localparam int          src_count     = 16;

  // ------------------------------------------------------------------
  // Field positions: modulator_control
  // ------------------------------------------------------------------
  localparam int ctl_enable_bit     = 7;
  localparam int ctl_out_state_bit  = 5;
  localparam int ctl_slew_limit_bit = 4;
  localparam int ctl_out_invert_bit = 2;
  localparam int ctl_sw_value_bit   = 0;

  // ------------------------------------------------------------------
  // Field positions: source and carrier registers
  // ------------------------------------------------------------------
  localparam int sel_lsb          = 0;
  localparam int pin_release_bit  = 7;
  localparam int carrier_inv_bit  = 6;

  // ------------------------------------------------------------------
  // Reset values and encodings
  // ------------------------------------------------------------------
  localparam logic [7:0] modulator_control_reset = 8'h10;
  localparam logic [7:0] source_reset            = 8'h00;
  localparam logic [3:0] sw_value_select         = 4'h0;
  localparam logic [1:0] resp_okay               = 2'h0;
  localparam logic [1:0] resp_slverr             = 2'h2;

endpackage : modulator_pkg

// [src/modulator_core.sv]
// Combinational mixing path from selected sources to the modulated pin
`timescale 1ns/1ns
module modulator_core (
  input  wire logic [15:0] mod_sources,
  input  wire logic [15:0] car_sources,
  input  wire logic [3:0]  mod_sel,
  input  wire logic [3:0]  car_high_sel,
  input  wire logic [3:0]  car_low_sel,
  input  wire logic        sw_value,
  input  wire logic        car_high_inv,
  input  wire logic        car_low_inv,
  input  wire logic        enable,
  input  wire logic        out_inv,
  output logic             mixed
);

  logic mod_sig;
  logic car_high;
  logic car_low;

  // Modulation selection 0 is the software value; all other selections index a source bus
  always_comb begin
    if (mod_sel == modulator_pkg::sw_value_select) begin
      mod_sig = sw_value; // R5
    end else begin
      mod_sig = mod_sources[mod_sel];
    end
    car_high = car_sources[car_high_sel] ^ car_high_inv; // R1
    car_low  = car_sources[car_low_sel] ^ car_low_inv;   // R2
  end

  // No sleep gating: follows sources whatever the power state
  always_comb begin
    if (enable) begin
      mixed = (mod_sig ? car_high : car_low) ^ out_inv; // R14 R7 R9 R10
    end else begin
      mixed = out_inv; // R15 R7
    end
  end

endmodule : modulator_core

// [src/signal_modulator.sv]
// Signal modulator top: AXI4-Lite register slave, pin releases and output pin
`timescale 1ns/1ns
// Function
// [R1] Invert carrier high source when bit set
// [R2] Invert carrier low source when bit set
// [R3] Release carrier high peripheral's own pin
// [R4] Release carrier low peripheral's own pin
// [R5] Software value selectable as modulating signal
// [R6] Release modulating peripheral's own pin
// [R7] Output invert complements the modulated pin
// [R8] Slew limit on by default, cleared removes
// [R9] Sleep leaves modulator state untouched
// [R10] Keeps running in sleep with live sources
// [R11] Reset clears the modulator enable
// [R12] Reset restores every configuration register
// [R13] Software configures sources before enabling output
// [R14] Carrier high when modulation high, else low
// [R15] Disabled output holds low before inversion
module signal_modulator (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] mod_sources,
  input  wire logic [15:0] car_sources,
  output logic [15:0]      mod_pin_release,
  output logic [15:0]      car_pin_release,
  output logic             modulated_output_pin,
  output logic             output_slew_limit
);

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  logic [7:0] modulator_control;
  logic [7:0] modulation_source_select;
  logic [7:0] carrier_high_control;
  logic [7:0] carrier_low_control;
  logic       mixed;
  logic       pin_state;

  // ------------------------------------------------------------------
  // Write channel state
  // ------------------------------------------------------------------
  logic       aw_held;
  logic [3:0] aw_addr;
  logic       w_held;
  logic [7:0] w_byte;
  logic       w_lane;
  logic       do_write;

  typedef enum logic [0:0] {
    rd_idle = 1'b0,
    rd_resp = 1'b1
  } rd_state_t;
  rd_state_t rd_state;

  // Decode of the four words; anything else is unmapped
  function automatic logic is_mapped(input logic [3:0] addr);
    is_mapped = (addr == modulator_pkg::modulator_control_addr) ||
                (addr == modulator_pkg::modulation_source_addr) ||
                (addr == modulator_pkg::carrier_high_control_addr) ||
                (addr == modulator_pkg::carrier_low_control_addr);
  endfunction : is_mapped

  // One-hot release mask for the selected source, zero when not releasing
  function automatic logic [15:0] release_mask(input logic [7:0] reg_val);
    release_mask = 16'h0000;
    if (reg_val[modulator_pkg::pin_release_bit]) begin
      release_mask[reg_val[3:0]] = 1'b1;
    end
  endfunction : release_mask

  // Address and data may arrive in either order; each is held until both
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  // ------------------------------------------------------------------
  // Write address and data capture
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr[3:2], 2'b00};
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= modulator_pkg::resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(aw_addr) ? modulator_pkg::resp_okay
                                         : modulator_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Register storage; only byte lane 0 carries data
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulator_control <= modulator_pkg::modulator_control_reset; // R11 R12 R8
    end else if (do_write && w_lane &&
                 aw_addr == modulator_pkg::modulator_control_addr) begin
      // Status bit is read-only and never stored
      modulator_control <= w_byte & ~(8'h01 << modulator_pkg::ctl_out_state_bit);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulation_source_select <= modulator_pkg::source_reset; // R12
    end else if (do_write && w_lane &&
                 aw_addr == modulator_pkg::modulation_source_addr) begin
      modulation_source_select <= w_byte & 8'h8f;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier_high_control <= modulator_pkg::source_reset; // R12
    end else if (do_write && w_lane &&
                 aw_addr == modulator_pkg::carrier_high_control_addr) begin
      carrier_high_control <= w_byte & 8'hcf;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carrier_low_control <= modulator_pkg::source_reset; // R12
    end else if (do_write && w_lane &&
                 aw_addr == modulator_pkg::carrier_low_control_addr) begin
      carrier_low_control <= w_byte & 8'hcf;
    end
  end

  // ------------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------------
  assign s_axi_arready = (rd_state == rd_idle);

  // Output state is shown live in the control word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state    <= rd_idle;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= modulator_pkg::resp_okay;
    end else begin
      case (rd_state)
        rd_idle: begin
          if (s_axi_arvalid) begin
            rd_state     <= rd_resp;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= modulator_pkg::resp_okay;
            case ({s_axi_araddr[3:2], 2'b00})
              modulator_pkg::modulator_control_addr:
                s_axi_rdata <= {24'h000000, modulator_control |
                  (8'(pin_state) << modulator_pkg::ctl_out_state_bit)};
              modulator_pkg::modulation_source_addr:
                s_axi_rdata <= {24'h000000, modulation_source_select};
              modulator_pkg::carrier_high_control_addr:
                s_axi_rdata <= {24'h000000, carrier_high_control};
              modulator_pkg::carrier_low_control_addr:
                s_axi_rdata <= {24'h000000, carrier_low_control};
              default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= modulator_pkg::resp_slverr;
              end
            endcase
          end
        end
        rd_resp: begin
          if (s_axi_rready) begin
            rd_state     <= rd_idle;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state     <= rd_idle;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Mixing path
  // ------------------------------------------------------------------
  modulator_core core (
    .mod_sources  (mod_sources),
    .car_sources  (car_sources),
    .mod_sel      (modulation_source_select[3:0]),
    .car_high_sel (carrier_high_control[3:0]),
    .car_low_sel  (carrier_low_control[3:0]),
    .sw_value     (modulator_control[modulator_pkg::ctl_sw_value_bit]),
    .car_high_inv (carrier_high_control[modulator_pkg::carrier_inv_bit]),
    .car_low_inv  (carrier_low_control[modulator_pkg::carrier_inv_bit]),
    .enable       (modulator_control[modulator_pkg::ctl_enable_bit]),
    .out_inv      (modulator_control[modulator_pkg::ctl_out_invert_bit]),
    .mixed        (mixed)
  );

  // Registered pin keeps glitches of the source mux off the pad
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_state <= 1'b0; // R11
    end else begin
      pin_state <= mixed; // R14 R7
    end
  end

  assign modulated_output_pin = pin_state;
  assign output_slew_limit = modulator_control[modulator_pkg::ctl_slew_limit_bit]; // R8

  // Pin releases; modulation selection 0 is the software value, which owns no pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_pin_release <= 16'h0000;
      car_pin_release <= 16'h0000;
    end else begin
      // Software value owns no pin, so selecting it never releases one
      if (modulation_source_select[3:0] == modulator_pkg::sw_value_select) begin
        mod_pin_release <= 16'h0000; // R6
      end else begin
        mod_pin_release <= release_mask(modulation_source_select); // R6
      end
      car_pin_release <= release_mask(carrier_high_control) | // R3
                         release_mask(carrier_low_control);   // R4
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Held off through reset; a_reset_clears watches the reset itself
  property p_disabled_low;
    @(posedge aclk) disable iff (!aresetn)
      !modulator_control[modulator_pkg::ctl_enable_bit] |=>
      modulated_output_pin == $past(modulator_control[modulator_pkg::ctl_out_invert_bit]);
  endproperty
  a_disabled_low: assert property (p_disabled_low) // R15
    else $error("disabled output not at inactive level");

  property p_mix;
    @(posedge aclk) disable iff (!aresetn)
      modulator_control[modulator_pkg::ctl_enable_bit] |=>
      modulated_output_pin == $past(mixed);
  endproperty
  a_mix: assert property (p_mix) // R14
    else $error("output does not follow mix");

  property p_reset_clears;
    @(posedge aclk) !aresetn |=> !modulator_control[modulator_pkg::ctl_enable_bit] &&
      output_slew_limit && modulation_source_select == 8'h00;
  endproperty
  a_reset_clears: assert property (p_reset_clears) // R11
    else $error("reset did not restore defaults");

  property p_slew;
    @(posedge aclk) disable iff (!aresetn)
      output_slew_limit == modulator_control[modulator_pkg::ctl_slew_limit_bit];
  endproperty
  a_slew: assert property (p_slew) // R8
    else $error("slew control mismatch");

  property p_ch_release;
    @(posedge aclk) disable iff (!aresetn)
      carrier_high_control[modulator_pkg::pin_release_bit] |=>
      car_pin_release[$past(carrier_high_control[3:0])];
  endproperty
  a_ch_release: assert property (p_ch_release) // R3
    else $error("carrier high pin not released");

  property p_cl_release;
    @(posedge aclk) disable iff (!aresetn)
      carrier_low_control[modulator_pkg::pin_release_bit] |=>
      car_pin_release[$past(carrier_low_control[3:0])];
  endproperty
  a_cl_release: assert property (p_cl_release) // R4
    else $error("carrier low pin not released");

  property p_ms_release;
    @(posedge aclk) disable iff (!aresetn)
      $stable(modulation_source_select) |->
      mod_pin_release == (modulation_source_select[3:0] == modulator_pkg::sw_value_select ?
                          16'h0000 : release_mask($past(modulation_source_select)));
  endproperty
  a_ms_release: assert property (p_ms_release) // R6
    else $error("modulation pin release mismatch");

  property p_sw_value;
    @(posedge aclk) disable iff (!aresetn)
      (modulator_control[modulator_pkg::ctl_enable_bit] &&
       modulation_source_select[3:0] == modulator_pkg::sw_value_select &&
       modulator_control[modulator_pkg::ctl_sw_value_bit]) |->
      mixed == ((car_sources[carrier_high_control[3:0]] ^
                 carrier_high_control[modulator_pkg::carrier_inv_bit]) ^
                modulator_control[modulator_pkg::ctl_out_invert_bit]);
  endproperty
  a_sw_value: assert property (p_sw_value) // R5
    else $error("software value modulation wrong");

endmodule : signal_modulator

// [testbench/source_model.sv]
// Behavioural model of the peripherals feeding modulating and carrier sources
`timescale 1ns/1ns
module source_model (
  input  wire logic        aclk,
  input  wire logic        run,
  output logic [15:0]      mod_sources,
  output logic [15:0]      car_sources
);
  logic [15:0] cnt;

  // ----------------------------------------------------------------
  // Source generation
  // ----------------------------------------------------------------
  // Carrier low bits and modulating high bits change fast, the others slowly; run low freezes all
  // sources, as peripherals stopped in sleep would
  initial cnt = 16'h0000;
  always @(posedge aclk) begin
    if (run) begin
      cnt <= cnt + 16'h0001;
    end
  end
  assign car_sources = cnt ^ 16'h5a3c;
  assign mod_sources = {cnt[7:0], cnt[15:8]} ^ 16'hc3a5;
endmodule : source_model

// [testbench/testbench.sv]
// Self-checking bench: AXI4-Lite register tasks and mixing checks
`timescale 1ns/1ns
module testbench;
  logic aclk, aresetn, run;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] mod_sources, car_sources, mod_pin_release, car_pin_release;
  logic modulated_output_pin, output_slew_limit;
  logic [7:0]  ctl, msrc, chc, clc;
  logic [31:0] rd;
  int errors, num_checks;

  signal_modulator DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mod_sources(mod_sources),
    .car_sources(car_sources), .mod_pin_release(mod_pin_release),
    .car_pin_release(car_pin_release), .modulated_output_pin(modulated_output_pin),
    .output_slew_limit(output_slew_limit));
  source_model partner (.aclk(aclk), .run(run), .mod_sources(mod_sources),
    .car_sources(car_sources));

  // ----------------------------------------------------------------
  // Clock, comparison and closing
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Watchdog: the whole run needs far fewer than 50000 cycles
  initial begin
    #200000;
    errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Bus tasks; ready is looked at on the falling edge, where it is settled
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d}; s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(negedge aclk);
      if (s_axi_awready === 1'b1) aw_d = 1'b1;
      if (s_axi_wready === 1'b1) w_d = 1'b1;
      @(posedge aclk);
      if (aw_d) s_axi_awvalid <= 1'b0;
      if (w_d) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, modulator_pkg::resp_okay});
    @(posedge aclk); // bready stays high, so the response is taken at this edge
    case (a)
      4'h0: ctl = d & 8'hdf;
      4'h4: msrc = d & 8'h8f;
      4'h8: chc = d & 8'hcf;
      default: clc = d & 8'hcf;
    endcase
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    @(posedge aclk); // rready stays high, so the data is taken at this edge
  endtask : rdr
  // Register file compared with the mirror; bit 5 of control is status only
  task automatic regs_chk;
    // Status bit shows the pin; callers keep the pin steady while reading
    rdr(4'h0); chk(rd, {24'h0, ctl | (8'(exp_pin(mod_sources, car_sources)) << 5)});
    rdr(4'h4); chk(rd, {24'h0, msrc});
    rdr(4'h8); chk(rd, {24'h0, chc});
    rdr(4'hc); chk(rd, {24'h0, clc});
  endtask : regs_chk
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    ctl = modulator_pkg::modulator_control_reset;
    {msrc, chc, clc} = {3{modulator_pkg::source_reset}};
    @(posedge aclk);
  endtask : do_reset

  // ----------------------------------------------------------------
  // Expected pin: one cycle after the sources and settings it mixes
  // ----------------------------------------------------------------
  function automatic logic exp_pin(input logic [15:0] m, input logic [15:0] c);
    logic mv, h, l, x;
    mv = (msrc[3:0] == modulator_pkg::sw_value_select) ? ctl[0] : m[msrc[3:0]];
    h = c[chc[3:0]] ^ chc[6];
    l = c[clc[3:0]] ^ clc[6];
    x = ctl[7] ? (mv ? h : l) : 1'b0;
    return x ^ ctl[2];
  endfunction : exp_pin
  task automatic mix_chk(input int n);
    logic e;
    @(negedge aclk);
    repeat (n) begin
      e = exp_pin(mod_sources, car_sources);
      @(negedge aclk);
      chk({31'h0, modulated_output_pin}, {31'h0, e});
    end
    @(posedge aclk);
  endtask : mix_chk
  task automatic rel_chk;
    logic [15:0] em, ec;
    @(negedge aclk);
    em = (msrc[7] && msrc[3:0] != 4'h0) ? (16'h0001 << msrc[3:0]) : 16'h0000;
    ec = (chc[7] ? (16'h0001 << chc[3:0]) : 16'h0000) |
         (clc[7] ? (16'h0001 << clc[3:0]) : 16'h0000);
    chk({16'h0, mod_pin_release}, {16'h0, em});
    chk({16'h0, car_pin_release}, {16'h0, ec});
    @(posedge aclk);
  endtask : rel_chk

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {errors, num_checks} = 0;
    run = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h000; s_axi_wdata = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    do_reset();
    regs_chk();
    chk({31'h0, output_slew_limit}, 32'h1);
    mix_chk(3);
    rel_chk();
    $display("test reset_defaults done");
    wr(4'h0, 8'h14); mix_chk(3);
    wr(4'h4, 8'hff); wr(4'h8, 8'hff); wr(4'hc, 8'hff); regs_chk();
    $display("test masks_disabled done");
    // Software value as modulator, both levels
    wr(4'h4, 8'h00); wr(4'h8, 8'h03); wr(4'hc, 8'h45);
    wr(4'h0, 8'h91); mix_chk(6);
    wr(4'h0, 8'h90); mix_chk(6);
    $display("test software_value done");
    for (int i = 1; i < 16; i++) begin
      wr(4'h0, 8'h10);
      wr(4'h4, (i[0] ? 8'h80 : 8'h00) | 8'(i));
      wr(4'h8, (i[1] ? 8'h80 : 8'h00) | (i[2] ? 8'h40 : 8'h00) | 8'((i * 3) & 15));
      wr(4'hc, (i[2] ? 8'h80 : 8'h00) | (i[0] ? 8'h40 : 8'h00) | 8'((i * 7) & 15));
      wr(4'h0, 8'h90 | (i[3] ? 8'h04 : 8'h00));
      mix_chk(8);
      rel_chk();
    end
    $display("test source_table done");
    wr(4'h0, 8'h84);
    chk({31'h0, output_slew_limit}, 32'h0);
    mix_chk(4);
    $display("test slew_clear done");
    // Sources stopped as in sleep, then running again
    run <= 1'b0; mix_chk(4); regs_chk();
    run <= 1'b1; mix_chk(6);
    $display("test sleep done");
    do_reset();
    regs_chk();
    mix_chk(3);
    chk({31'h0, output_slew_limit}, 32'h1);
    rel_chk();
    $display("test mid_reset done");
    test_done();
  end
endmodule : testbench
